// File: iad_pkg.sv
// constants and types shared by the interrupt acknowledge and dispatch block
package iad_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam logic [15:0] STATE_CYC = 16'h0001;
	localparam int unsigned LATE_STATES = 4;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_MASK = 8'h04;
	localparam logic [7:0] OFF_PEND = 8'h08;
	localparam logic [7:0] OFF_SEL = 8'h0C;
	localparam logic [7:0] OFF_DONE = 8'h10;
	localparam logic [7:0] OFF_SRVCFG = 8'h14;
	localparam logic [7:0] OFF_STAT = 8'h18;
	localparam logic [1:0] OFF_CNT_HI = 2'h1;
	localparam int unsigned CTRL_IE = 0;
	localparam int unsigned CTRL_SE = 1;
	localparam int unsigned CTRL_MODE1M = 2;
	localparam int unsigned CTRL_XSTK = 3;
	localparam int unsigned CFG_BLOCK = 0;
	localparam int unsigned CFG_MOVE_LO = 1;
	localparam int unsigned CFG_LEN_LO = 8;
	localparam logic [3:0] RST_CTRL = 4'h0;
	localparam logic [15:0] RST_MASK = 16'h0000;
	localparam logic [15:0] RST_PEND = 16'h0000;
	localparam logic [15:0] RST_SEL = 16'h0000;
	localparam logic [15:0] RST_DONE = 16'h0000;
	localparam logic [15:0] RST_SRVCFG = 16'h0000;
	localparam logic [7:0] RST_CNT = 8'h00;
	localparam logic [3:0] SRC_NMI = 4'hF;
	localparam logic [15:0] SEL_WRITABLE = 16'h5FFF;
	localparam logic [15:0] SRC_VALID = 16'hDFFF;
	localparam logic [15:0] STD_64_INT = 16'h000B;
	localparam logic [15:0] STD_64_EXT = 16'h000D;
	localparam logic [15:0] STD_1M_INT = 16'h000F;
	localparam logic [15:0] STD_1M_EXT = 16'h0012;
	localparam logic [15:0] SGL_RR = 16'h0012;
	localparam logic [15:0] SGL_MR = 16'h0015;
	localparam logic [15:0] SGL_MM = 16'h0018;
	localparam logic [15:0] SGL_EXTRA = 16'h0001;
	localparam logic [15:0] BLK_RR = 16'h000D;
	localparam logic [15:0] BLK_MR = 16'h0010;
	localparam logic [15:0] BLK_MM = 16'h0013;
	localparam logic [15:0] BLK_PER = 16'h0007;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {IAD_MOVE_RR, IAD_MOVE_MR, IAD_MOVE_MM} iad_move_t;
	typedef enum logic [1:0] {IAD_IDLE, IAD_STD_CALL, IAD_SERVER} iad_state_t;
endpackage : iad_pkg

// File: iad_prio_enc.sv
// priority encoder: index of the highest set request bit
module iad_prio_enc #(
	parameter int unsigned W = 32
) (
	input wire logic [W-1:0] req,
	output logic any,
	output logic [$clog2(W)-1:0] idx
);
	always_comb begin
		any = 1'b0;
		idx = '0;
		for (int i = 0; i < W; i++) begin
			if (req[i]) begin
				any = 1'b1;
				idx = i[$clog2(W)-1:0];
			end
		end
	end
endmodule : iad_prio_enc

// File: iad_dispatch.sv
// interrupt acknowledge and dispatch with axi4-lite register slave
// Overview of operation
// - ack only at instruction end; requests in last four states wait one more
// - standard ack clears the pending bit and forces the vector call
// - server ack vectors at once to the server control block
// - prefix, protected and read-modify-write instructions defer ack past next instruction
// - after unimplemented-opcode or trap, no ack until next instruction executed
// - a server cycle, whole block included, is never interrupted
// - 64k mode vector call costs 11 internal-stack or 13 external-stack states
// - 1m mode vector call costs 15 internal-stack or 18 external-stack states
// - single transfer costs 18, 21 or 24 states per item plus one
// - block transfer costs 13, 16 or 19 plus 7 per item, one minimum
// - set mask bit enables a source; nmi bit does not gate nmi
// - mask set and select clear gives standard; both set gives server
// - with interrupts disabled servers still run; done requests are not serviced
// - requests set pending bits even while interrupts are disabled
// - mask bit 0 gates the shared event-array interrupt
// - nmi above all server requests, server above all standard
// - count reaching zero sets the done request, served as standard
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
module iad_dispatch (
	input wire logic clk,
	input wire logic reset,
	input wire logic [15:0] irq_req,
	input wire logic instr_done,
	input wire logic instr_last_states,
	input wire logic instr_deferring,
	input wire logic instr_trap,
	output logic cpu_hold,
	output logic ack,
	output logic [3:0] ack_source,
	output logic ack_server,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import iad_pkg::*;

	function automatic logic [15:0] iad_merge(input logic [15:0] old, input logic [15:0] d, input logic [1:0] s);
		iad_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : iad_merge

	function automatic logic [15:0] iad_std_cost(input logic m1m, input logic xstk);
		logic [15:0] st;
		st = m1m ? (xstk ? STD_1M_EXT : STD_1M_INT) : (xstk ? STD_64_EXT : STD_64_INT);
		iad_std_cost = 16'(st * STATE_CYC);
	endfunction : iad_std_cost

	function automatic logic [15:0] iad_srv_cost(input logic blk, input logic [1:0] mv, input logic [7:0] len);
		logic [15:0] st;
		logic [15:0] items;
		items = (len == 8'h00) ? 16'h0001 : {8'h00, len};
		if (blk) begin
			st = (mv == IAD_MOVE_RR) ? BLK_RR : (mv == IAD_MOVE_MR) ? BLK_MR : BLK_MM;
			st = 16'(st + 16'(BLK_PER * items));
		end else begin
			st = (mv == IAD_MOVE_RR) ? SGL_RR : (mv == IAD_MOVE_MR) ? SGL_MR : SGL_MM;
			st = 16'(st + SGL_EXTRA);
		end
		iad_srv_cost = 16'(st * STATE_CYC);
	endfunction : iad_srv_cost

	logic [3:0] ctrl;
	logic [15:0] mask;
	logic [15:0] pend;
	logic [15:0] sel;
	logic [15:0] done;
	logic [15:0] srvcfg;
	logic [7:0] cnt [16];
	logic [15:0] fresh;
	logic [15:0] left;
	iad_state_t state;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// bus slave
	wire wr_fire = aw_held && w_held && !s_axi_bvalid;
	wire rd_fire = s_axi_arvalid && s_axi_arready;
	wire [15:0] wd = w_data[15:0];
	wire wr_ctrl = wr_fire && aw_addr == OFF_CTRL;
	wire wr_mask = wr_fire && aw_addr == OFF_MASK;
	wire wr_pend = wr_fire && aw_addr == OFF_PEND;
	wire wr_sel = wr_fire && aw_addr == OFF_SEL;
	wire wr_done = wr_fire && aw_addr == OFF_DONE;
	wire wr_cfg = wr_fire && aw_addr == OFF_SRVCFG;
	wire wr_cnt = wr_fire && aw_addr[7:6] == OFF_CNT_HI && aw_addr[1:0] == 2'h0;
	wire wr_hit = wr_ctrl | wr_mask | wr_pend | wr_sel | wr_done | wr_cfg | wr_cnt;
	wire wr_stat = wr_fire && aw_addr == OFF_STAT;
	wire [7:0] ra = s_axi_araddr;
	wire rd_cnt = ra[7:6] == OFF_CNT_HI && ra[1:0] == 2'h0;
	wire rd_hit = rd_cnt || ra == OFF_CTRL || ra == OFF_MASK || ra == OFF_PEND || ra == OFF_SEL
		|| ra == OFF_DONE || ra == OFF_SRVCFG || ra == OFF_STAT;
	wire [15:0] stat = {8'h00, ack_server, ack_source, 1'b0, state};
	wire [15:0] rd_word = rd_cnt ? {8'h00, cnt[ra[5:2]]} :
		ra == OFF_CTRL ? {12'h000, ctrl} :
		ra == OFF_MASK ? mask :
		ra == OFF_PEND ? pend :
		ra == OFF_SEL ? sel :
		ra == OFF_DONE ? done :
		ra == OFF_SRVCFG ? srvcfg : stat;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk) begin
		if (reset) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_hit || wr_stat) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {16'h0000, rd_hit ? rd_word : 16'h0000};
			s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// candidates and priority
	wire ie = ctrl[CTRL_IE];
	wire se = ctrl[CTRL_SE];
	wire [15:0] live = pend & ~fresh & SRC_VALID;
	wire nmi_c = live[SRC_NMI];
	wire [15:0] srv_c = live & mask & sel & SEL_WRITABLE & {16{se}};
	wire [15:0] std_c = ((live & ~sel) | done) & mask & ~16'h8000 & {16{ie}};
	wire [31:0] cand = {nmi_c, srv_c[14:0], 1'b0, std_c[14:0]};
	wire pe_any;
	wire [4:0] pe_idx;

	iad_prio_enc #(.W(32)) u_prio (
		.req(cand),
		.any(pe_any),
		.idx(pe_idx)
	);

	wire ack_ok = instr_done && !instr_deferring && !instr_trap && state == IAD_IDLE;
	wire take = ack_ok && pe_any;
	wire [3:0] src = pe_idx[3:0];
	wire take_srv = take && pe_idx[4] && src != SRC_NMI;
	wire take_std = take && !take_srv;
	wire done_hit = take_std && done[src];
	wire cnt_zero = cnt[src] <= 8'h01;
	wire [15:0] src_bit = 16'h0001 << src;
	wire [15:0] clr_pend = (take && !done_hit) ? src_bit : 16'h0000;
	wire [15:0] clr_done = done_hit ? src_bit : 16'h0000;
	wire [15:0] hw_done = (take_srv && cnt_zero) ? src_bit : 16'h0000;
	wire [15:0] pend_sw = wr_pend ? iad_merge(pend, wd, w_strb[1:0]) : pend;
	wire [15:0] done_sw = wr_done ? done & ~iad_merge(16'h0000, wd, w_strb[1:0]) : done;
	wire [15:0] sel_sw = wr_sel ? iad_merge(sel, wd, w_strb[1:0]) & SEL_WRITABLE : sel;
	wire [15:0] next_pend = ((pend_sw & ~clr_pend) | irq_req) & SRC_VALID;
	wire [15:0] next_done = (done_sw & ~clr_done) | hw_done;
	wire [15:0] next_sel = sel_sw & ~hw_done;
	wire [15:0] next_fresh = instr_done ? 16'h0000 : fresh | (irq_req & {16{instr_last_states}});
	wire [15:0] std_cost = iad_std_cost(ctrl[CTRL_MODE1M], ctrl[CTRL_XSTK]);
	wire [15:0] srv_cost = iad_srv_cost(srvcfg[CFG_BLOCK], srvcfg[CFG_MOVE_LO +: 2], srvcfg[CFG_LEN_LO +: 8]);

	assign cpu_hold = take || state != IAD_IDLE;

	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl <= RST_CTRL;
			mask <= RST_MASK;
			srvcfg <= RST_SRVCFG;
			pend <= RST_PEND;
			sel <= RST_SEL;
			done <= RST_DONE;
			fresh <= 16'h0000;
		end else begin
			if (wr_ctrl) ctrl <= wd[3:0];
			if (wr_mask) mask <= iad_merge(mask, wd, w_strb[1:0]);
			if (wr_cfg) srvcfg <= iad_merge(srvcfg, wd, w_strb[1:0]);
			pend <= next_pend;
			sel <= next_sel;
			done <= next_done;
			fresh <= next_fresh;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < 16; i++) cnt[i] <= RST_CNT;
		end else begin
			if (take_srv && cnt[src] != 8'h00) cnt[src] <= cnt[src] - 8'h01;
			if (wr_cnt) cnt[aw_addr[5:2]] <= wd[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= IAD_IDLE;
			left <= 16'h0000;
			ack <= 1'b0;
			ack_source <= 4'h0;
			ack_server <= 1'b0;
		end else begin
			ack <= take;
			if (take) begin
				ack_source <= src;
				ack_server <= take_srv;
			end
			case (state)
				IAD_IDLE: begin
					if (take) begin
						state <= take_srv ? IAD_SERVER : IAD_STD_CALL;
						left <= take_srv ? srv_cost : std_cost;
					end
				end
				IAD_STD_CALL, IAD_SERVER: begin
					left <= 16'(left - 16'h0001);
					if (left == 16'h0001) state <= IAD_IDLE;
				end
				default: begin
					state <= IAD_IDLE;
					left <= 16'h0000;
				end
			endcase
		end
	end

	property p_ack_at_end;
		@(posedge clk) disable iff (reset) ack |-> $past(instr_done) && !$past(fresh[src]);
	endproperty
	a_ack_at_end: assert property (p_ack_at_end) else $error("ack not at instruction end");
	property p_defer;
		@(posedge clk) disable iff (reset) instr_done && instr_deferring |=> !ack;
	endproperty
	a_defer: assert property (p_defer) else $error("ack after deferring instruction");
	property p_trap;
		@(posedge clk) disable iff (reset) instr_done && instr_trap |=> !ack;
	endproperty
	a_trap: assert property (p_trap) else $error("ack right after trap");
	property p_std_clear;
		@(posedge clk) disable iff (reset)
			take_std && !done_hit && !irq_req[src] && !wr_pend |=> !pend[ack_source];
	endproperty
	a_std_clear: assert property (p_std_clear) else $error("pending bit not cleared");
	property p_no_nest;
		@(posedge clk) disable iff (reset) state != IAD_IDLE |-> !take;
	endproperty
	a_no_nest: assert property (p_no_nest) else $error("ack during service");
	property p_std_cost;
		@(posedge clk) disable iff (reset) take_std |=> left == $past(std_cost) && state == IAD_STD_CALL;
	endproperty
	a_std_cost: assert property (p_std_cost) else $error("wrong vector call cost");
	property p_srv_cost;
		@(posedge clk) disable iff (reset) take_srv |=> left == $past(srv_cost) && state == IAD_SERVER;
	endproperty
	a_srv_cost: assert property (p_srv_cost) else $error("wrong server cycle cost");
	property p_mask;
		@(posedge clk) disable iff (reset)
			take && src != SRC_NMI |-> mask[src] && (take_srv ? sel[src] : (!sel[src] || done_hit));
	endproperty
	a_mask: assert property (p_mask) else $error("masked or misrouted source taken");
	property p_ie;
		@(posedge clk) disable iff (reset) take_std && src != SRC_NMI |-> ie;
	endproperty
	a_ie: assert property (p_ie) else $error("standard ack while disabled");
	property p_pend;
		@(posedge clk) disable iff (reset)
			irq_req != 16'h0000 |=> (pend & $past(irq_req & SRC_VALID)) == $past(irq_req & SRC_VALID);
	endproperty
	a_pend: assert property (p_pend) else $error("request lost");
	property p_prio;
		@(posedge clk) disable iff (reset) take && nmi_c |-> src == SRC_NMI ##1 ack && !ack_server;
	endproperty
	a_prio: assert property (p_prio) else $error("nmi not first");
	property p_done;
		@(posedge clk) disable iff (reset) take_srv && cnt_zero && !wr_sel |=> done[ack_source] && !sel[ack_source];
	endproperty
	a_done: assert property (p_done) else $error("count end not handled");
	property p_fresh;
		@(posedge clk) disable iff (reset)
			instr_last_states && !instr_done && irq_req != 16'h0000 |=> (fresh & $past(irq_req)) == $past(irq_req);
	endproperty
	a_fresh: assert property (p_fresh) else $error("late request not held back");
	property p_srv_path;
		@(posedge clk) disable iff (reset) take_srv |=> ack && ack_server && state == IAD_SERVER;
	endproperty
	a_srv_path: assert property (p_srv_path) else $error("server ack not vectored at once");
	property p_busy;
		@(posedge clk) disable iff (reset) state != IAD_IDLE && left != 16'h0001 |=> state == $past(state);
	endproperty
	a_busy: assert property (p_busy) else $error("service cycle ended early");
	property p_srv_first;
		@(posedge clk) disable iff (reset) take && !nmi_c && srv_c != 16'h0000 |-> take_srv;
	endproperty
	a_srv_first: assert property (p_srv_first) else $error("standard taken over server");
	property p_sel_rsvd;
		@(posedge clk) disable iff (reset) (sel & ~SEL_WRITABLE) == 16'h0000;
	endproperty
	a_sel_rsvd: assert property (p_sel_rsvd) else $error("reserved select bit set");
	c_std: cover property (@(posedge clk) disable iff (reset) take_std ##1 cpu_hold[*8]);
	c_srv: cover property (@(posedge clk) disable iff (reset) take_srv && cnt_zero);
	c_late: cover property (@(posedge clk) disable iff (reset) instr_done && fresh != 16'h0000);
	c_done: cover property (@(posedge clk) disable iff (reset) done_hit);
	c_nmi: cover property (@(posedge clk) disable iff (reset) take && nmi_c);
endmodule : iad_dispatch

// File: iad_cpu_model.sv
// cpu sequencer model: instruction boundaries, stalls while the controller holds the core
module iad_cpu_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic cpu_hold,
	input wire logic [3:0] len_in,
	input wire logic defer_in,
	input wire logic trap_in,
	output logic instr_done,
	output logic instr_last_states,
	output logic instr_deferring,
	output logic instr_trap
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] rem;
	assign instr_done = (rem == 4'h1);
	assign instr_last_states = (rem <= 4'h4);
	// kind of instruction is latched at its start and held until its completion
	always_ff @(posedge clk) begin
		if (reset || instr_done) begin
			rem <= len_in;
			instr_deferring <= defer_in;
			instr_trap <= trap_in;
		end else if (!cpu_hold) begin
			rem <= rem - 4'h1;
		end
	end
endmodule : iad_cpu_model

// File: tb.sv
// self-checking testbench for the interrupt acknowledge and dispatch block
module tb;
	import iad_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset, instr_done, instr_last_states, instr_deferring, instr_trap;
	logic cpu_hold, ack, ack_server, defer_in, trap_in;
	logic [15:0] irq_req;
	logic [3:0] ack_source, len_in, s_axi_wstrb;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int failures, checks_done;
	iad_dispatch u_dut (.clk, .reset, .irq_req, .instr_done, .instr_last_states, .instr_deferring, .instr_trap,
		.cpu_hold, .ack, .ack_source, .ack_server, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	iad_cpu_model u_cpu (.clk, .reset, .cpu_hold, .len_in, .defer_in, .trap_in, .instr_done,
		.instr_last_states, .instr_deferring, .instr_trap);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) len_in <= 4'(6 + $urandom_range(0, 6));
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ah, wh, bh;
		ah = 1'b0;
		wh = 1'b0;
		bh = 1'b0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!bh) begin
			@(negedge clk);
			if (s_axi_awvalid && s_axi_awready) ah = 1'b1;
			if (s_axi_wvalid && s_axi_wready) wh = 1'b1;
			bh = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask : axi_write
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ah, rh;
		ah = 1'b0;
		rh = 1'b0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!rh) begin
			@(negedge clk);
			if (s_axi_arvalid && s_axi_arready) ah = 1'b1;
			rh = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk);
			if (ah) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask : axi_read
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axi_write(a, d, rs);
		check("write resp", 32'(rs), 32'(RESP_OKAY));
	endtask : wr
	task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		axi_read(a, rd, rs);
		check(name, rd, exp);
	endtask : rdchk
	function automatic logic [31:0] std_cost(input int m);
		return m == 0 ? 32'(STD_64_INT) : m == 1 ? 32'(STD_64_EXT) : m == 2 ? 32'(STD_1M_INT) : 32'(STD_1M_EXT);
	endfunction : std_cost
	function automatic logic [31:0] srv_cost(input logic [15:0] cfg);
		logic [31:0] n;
		n = (cfg[15:8] == 8'h00) ? 32'h1 : 32'(cfg[15:8]);
		case (cfg[2:1])
			2'h0: return cfg[0] ? BLK_RR + BLK_PER * n : 32'(SGL_RR + SGL_EXTRA);
			2'h1: return cfg[0] ? BLK_MR + BLK_PER * n : 32'(SGL_MR + SGL_EXTRA);
			default: return cfg[0] ? BLK_MM + BLK_PER * n : 32'(SGL_MM + SGL_EXTRA);
		endcase
	endfunction : srv_cost
	// kind: 0 plain, 1 late in instruction, 2 deferring instruction, 3 trap
	task automatic fire(input logic [15:0] bits, input int kind, input logic [3:0] es, input logic ev,
		input logic [31:0] ec);
		int n, dn, c;
		dn = 0;
		c = 0;
		if (bits != 16'h0000) begin
			defer_in <= (kind == 2);
			trap_in <= (kind == 3);
			@(negedge clk);
			while (instr_done !== 1'b1) @(negedge clk);
			@(posedge clk);
			defer_in <= 1'b0;
			trap_in <= 1'b0;
			if (kind == 1) begin
				@(negedge clk);
				while (instr_last_states !== 1'b1) @(negedge clk);
				@(posedge clk);
			end
			irq_req <= bits;
			@(posedge clk);
			irq_req <= 16'h0000;
		end
		for (n = 0; n < 300 && ack !== 1'b1; n++) begin
			@(negedge clk);
			if (instr_done === 1'b1) dn++;
		end
		check("ack points", dn, kind == 0 ? 1 : 2);
		check("ack source", 32'(ack_source), 32'(es));
		check("ack path", 32'(ack_server), 32'(ev));
		while (cpu_hold === 1'b1 && c < 400) begin
			@(negedge clk);
			c++;
		end
		check("hold cycles", c, ec);
	endtask : fire
	task automatic quiet;
		int k, n;
		n = 0;
		for (k = 0; k < 60; k++) begin
			@(negedge clk);
			if (ack !== 1'b0) n++;
		end
		check("stray ack", n, 0);
	endtask : quiet
	task automatic complete_run;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run
	initial begin
		#500000;
		failures++;
		complete_run;
	end
	initial begin
		int m, s, k;
		logic [7:0] regs[8];
		logic [15:0] cfg[5];
		regs = '{OFF_CTRL, OFF_MASK, OFF_PEND, OFF_SEL, OFF_DONE, OFF_SRVCFG, OFF_STAT, 8'h40};
		cfg = '{16'h0000, 16'h0002, 16'h0004, 16'h0001, 16'h0203};
		void'($urandom(32'hF1E24635));
		{reset, irq_req, defer_in, trap_in, len_in, s_axi_wstrb} = {1'b1, 16'h0000, 2'h0, 4'h6, 4'hF};
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		for (k = 0; k < 8; k++) rdchk("reset value", regs[k], 32'h0);
		axi_read(8'h30, rd, rs);
		check("unmapped read resp", 32'(rs), 32'(RESP_SLVERR));
		check("unmapped read data", rd, 32'h0);
		axi_write(8'h30, 32'h0000FFFF, rs);
		check("unmapped write resp", 32'(rs), 32'(RESP_SLVERR));
		wr(OFF_SEL, 32'h0000FFFF);
		rdchk("select", OFF_SEL, 32'h00005FFF);
		wr(OFF_SEL, 32'h0);
		for (m = 0; m < 4; m++) begin
			s = $urandom_range(0, 13);
			if (s == 13) s = 14;
			wr(OFF_CTRL, 32'(1 + (m % 2) * 8 + (m / 2) * 4));
			wr(OFF_MASK, 32'(1 << s));
			fire(16'(1 << s), m, 4'(s), 1'b0, std_cost(m));
			rdchk("pending after call", OFF_PEND, 32'h0);
		end
		wr(OFF_CTRL, 32'h0);
		wr(OFF_MASK, 32'h0);
		@(posedge clk);
		irq_req <= 16'h0020;
		@(posedge clk);
		irq_req <= 16'h0000;
		quiet;
		rdchk("masked pending", OFF_PEND, 32'h00000020);
		fire(16'h8000, 0, 4'hF, 1'b0, 32'(STD_64_INT));
		wr(OFF_PEND, 32'h0);
		wr(OFF_CTRL, 32'h3);
		wr(OFF_MASK, 32'h1008);
		wr(OFF_SEL, 32'h1000);
		wr(8'h70, 32'h3);
		wr(OFF_SRVCFG, 32'h0305);
		fire(16'h9008, 0, 4'hF, 1'b0, 32'(STD_64_INT));
		fire(16'h0000, 0, 4'hC, 1'b1, srv_cost(16'h0305));
		fire(16'h0000, 0, 4'h3, 1'b0, 32'(STD_64_INT));
		rdchk("count", 8'h70, 32'h2);
		wr(OFF_CTRL, 32'h2);
		wr(OFF_MASK, 32'h1000);
		for (k = 0; k < 5; k++) begin
			wr(OFF_SEL, 32'h1000);
			wr(8'h70, 32'h1);
			wr(OFF_SRVCFG, 32'(cfg[k]));
			fire(16'h1000, 0, 4'hC, 1'b1, srv_cost(cfg[k]));
			rdchk("select cleared", OFF_SEL, 32'h0);
			rdchk("done request", OFF_DONE, 32'h1000);
		end
		quiet;
		// enable just after a completion so the done request is taken inside fire
		@(negedge clk);
		while (instr_done !== 1'b1) @(negedge clk);
		wr(OFF_CTRL, 32'h1);
		fire(16'h0000, 0, 4'hC, 1'b0, 32'(STD_64_INT));
		rdchk("done cleared", OFF_DONE, 32'h0);
		complete_run;
	end
endmodule : tb
